/* File: hdl/pst_pkg.sv */
// Purpose: constants and types of the pulse and sample timing block
// Assumes: clk at 100 MHz, all timing in 100 ns ticks
// Notes: times are kept in their own unit, tick counts derive from them
package pst_pkg;
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 100;
  localparam int TICK_DIV = TICK_NS / CLK_NS;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_DIV - 1);
  localparam int CNT_W = 19;
  localparam int DLY_W = 24;
  localparam int PTS_W = 10;
  localparam int PCT_W = 7;
  localparam int ACC_W = 27;
  localparam int QUO_W = 20;
  localparam int STEP_W = 5;
  localparam int MAX_WIDTH_NS = 40_880_000;
  localparam int MAX_TICKS = MAX_WIDTH_NS / TICK_NS;
  localparam int MIN_RES_NS = 100;
  localparam int RES_MIN_TICKS = (MIN_RES_NS + TICK_NS - 1) / TICK_NS;
  localparam int COARSE_NS = 10_000;
  localparam int COARSE_TICKS = COARSE_NS / TICK_NS;
  localparam int LEAD_INT_RES = 6;
  localparam int LAG_EXT_RES = 3;
  localparam int PCT_FULL = 100;
  localparam int PRP_SWEEP_NS = 30_000_000;
  localparam int PRP_PROF_NS = 3_000_000;
  localparam int PRP_AVG_NS = 1_000_000;
  localparam logic TRIG_IDLE = 1'h1;

  typedef logic [CNT_W-1:0] pst_cnt_type;
  typedef logic signed [DLY_W-1:0] pst_dly_type;
  typedef logic [PTS_W-1:0] pst_pts_type;
  typedef logic [PCT_W-1:0] pst_pct_type;

  localparam pst_cnt_type PRP_SWEEP_DEF = CNT_W'(PRP_SWEEP_NS / TICK_NS);
  localparam pst_cnt_type PRP_PROF_DEF = CNT_W'(PRP_PROF_NS / TICK_NS);
  localparam pst_cnt_type PRP_AVG_DEF = CNT_W'(PRP_AVG_NS / TICK_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DIV, ST_SETUP, ST_HOLD, ST_RUN
  } pst_state_type;
endpackage : pst_pkg

/* File: hdl/pst_cnt_if.sv */
// Purpose: carrier between the timing control and its tick counters
// Assumes: one clock, tick is a one-cycle enable
// Notes: done is a one-cycle pulse
`timescale 1ns/10ps
interface pst_cnt_if;
  logic tick;
  logic load;
  pst_pkg::pst_cnt_type val;
  logic done;
  modport owner(output tick, output load, output val, input done);
  modport counter(input tick, input load, input val, output done);
endinterface : pst_cnt_if

/* File: hdl/pst_down_counter.sv */
// Purpose: loadable tick down counter
// Assumes: load and tick from the owner, same clock
// Notes: loaded with N, done pulses after the (N+1)th tick
`timescale 1ns/10ps
module pst_down_counter (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // owner side
  pst_cnt_if.counter cnt
);
  import pst_pkg::*;

  pst_cnt_type cntFf, nxt_cnt;
  logic runFf, nxt_run;
  logic doneFf, nxt_done;

  assign cnt.done = doneFf;

  // ==========================================================
  // count
  always_comb begin
    nxt_cnt = cntFf;
    nxt_run = runFf;
    nxt_done = 1'h0;
    if (cnt.load) begin
      nxt_cnt = cnt.val;
      nxt_run = 1'h1;
    end else if (runFf && cnt.tick) begin
      if (cntFf == '0) begin
        nxt_run = 1'h0;
        nxt_done = 1'h1;
      end else begin
        nxt_cnt = cntFf - 1'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cntFf <= '0;
      runFf <= 1'h0;
      doneFf <= 1'h0;
    end else begin
      cntFf <= nxt_cnt;
      runFf <= nxt_run;
      doneFf <= nxt_done;
    end
  end
endmodule : pst_down_counter

/* File: hdl/pst_timing.sv */
// Purpose: pulse generation and sample trigger placement
// Assumes: all inputs synchronous to clk; widths and delays in 100 ns ticks
// Notes: one measurement run covers numPoints points (one if numPoints is zero), then returns idle
`timescale 1ns/10ps
module pst_timing #(
  parameter pst_pkg::pst_cnt_type PRP_SWEEP_TICKS = pst_pkg::PRP_SWEEP_DEF,
  parameter pst_pkg::pst_cnt_type PRP_PROF_TICKS = pst_pkg::PRP_PROF_DEF,
  parameter pst_pkg::pst_cnt_type PRP_AVG_TICKS = pst_pkg::PRP_AVG_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // measurement start sources
  input wire logic startInt,
  input wire logic startTtl,
  input wire logic startGet,
  // configuration
  input wire logic extTrig,
  input wire logic profileMode,
  input wire logic avgOn,
  input wire logic pulseActiveHigh,
  input wire pst_pkg::pst_cnt_type pulseWidth,
  input wire pst_pkg::pst_pct_type dutyLimit,
  input wire pst_pkg::pst_dly_type sweepDelay,
  input wire pst_pkg::pst_dly_type profStart,
  input wire pst_pkg::pst_cnt_type profStop,
  input wire pst_pkg::pst_pts_type numPoints,
  // setup handshake and external trigger
  input wire logic setupDone,
  input wire logic extTrigIn,
  // outputs
  output logic modOut,
  output logic sampleTrig,
  output logic tuneReq,
  output logic haltReady,
  output logic busy,
  output logic measDone,
  output pst_pkg::pst_pts_type pointIdx,
  output pst_pkg::pst_cnt_type resPeriod
);
  import pst_pkg::*;

  // ==========================================================
  // counters
  pst_cnt_if leadIf();
  pst_cnt_if widthIf();
  pst_cnt_if sampIf();

  pst_down_counter uLead (.clk(clk), .srst(srst), .cnt(leadIf.counter));
  pst_down_counter uWidth (.clk(clk), .srst(srst), .cnt(widthIf.counter));
  pst_down_counter uSamp (.clk(clk), .srst(srst), .cnt(sampIf.counter));

  function automatic pst_dly_type clampDly(pst_dly_type x, pst_dly_type lo);
    pst_dly_type r;
    r = x;
    if (x < lo) begin
      r = lo;
    end else if (x > pst_dly_type'(MAX_TICKS)) begin
      r = pst_dly_type'(MAX_TICKS);
    end
    return r;
  endfunction : clampDly

  // ==========================================================
  // 10 MHz timebase
  logic [DIV_W-1:0] divFf, nxt_div;
  logic tickFf, nxt_tick;
  logic trigPrevFf;
  logic zeroExt;
  pst_state_type stateFf, nxt_state;

  assign zeroExt = (stateFf == ST_HOLD) && extTrig && trigPrevFf &&
                   !extTrigIn;

  always_comb begin
    nxt_div = divFf + 1'h1;
    nxt_tick = 1'h0;
    if (zeroExt) begin
      // realign the grid to the external time zero
      nxt_div = '0;
    end else if (divFf == TICK_LAST) begin
      nxt_div = '0;
      nxt_tick = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      divFf <= '0;
      tickFf <= 1'h0;
      trigPrevFf <= TRIG_IDLE;
    end else begin
      divFf <= nxt_div;
      tickFf <= nxt_tick;
      trigPrevFf <= extTrigIn;
    end
  end

  assign leadIf.tick = tickFf;
  assign widthIf.tick = tickFf;
  assign sampIf.tick = tickFf;

  // ==========================================================
  // derived values
  pst_pts_type pts;
  pst_cnt_type span;
  logic [QUO_W-1:0] divisor, trial;
  pst_pct_type duty;
  logic [ACC_W-1:0] target;
  pst_cnt_type prdFloor;
  pst_cnt_type res;
  pst_dly_type minDly, useDly;
  pst_cnt_type preTicks, sampTicks, widthTicks;

  logic [QUO_W-1:0] remFf, nxt_rem, quoFf, nxt_quo;
  logic [STEP_W-1:0] stepFf, nxt_step;
  logic coarseFf, nxt_coarse;
  pst_cnt_type spaceFf, nxt_space;
  pst_dly_type curDlyFf, nxt_curDly;
  pst_pts_type idxFf, nxt_idx;
  logic firstFf, nxt_first;
  logic pendPulseFf, nxt_pendPulse;
  logic pendSampFf, nxt_pendSamp;
  logic pulseOnFf, nxt_pulseOn;
  pst_cnt_type prdCntFf, nxt_prdCnt;
  logic [ACC_W-1:0] accFf, nxt_acc;
  logic prdOk;
  logic modOutFf, nxt_modOut;
  logic sampTrigFf, nxt_sampTrig;
  logic tuneReqFf, nxt_tuneReq;
  logic haltFf, nxt_halt;
  logic busyFf, nxt_busy;
  logic doneFf, nxt_done;

  always_comb begin
    pts = (numPoints == '0) ? PTS_W'(1) : numPoints;
    span = (profStop > pulseWidth) ? profStop : pulseWidth;
    divisor = coarseFf ? QUO_W'(int'(pts) * COARSE_TICKS) : QUO_W'(pts);
    trial = {remFf[QUO_W-2:0], quoFf[QUO_W-1]};
    duty = dutyLimit;
    if (dutyLimit == '0) begin
      duty = PCT_W'(1);
    end else if (dutyLimit > PCT_W'(PCT_FULL)) begin
      duty = PCT_W'(PCT_FULL);
    end
    // zero width runs as one tick, so the duty bound must count it too
    target = ACC_W'((pulseWidth == '0) ? CNT_W'(1) : pulseWidth) *
             ACC_W'(PCT_FULL);
    prdFloor = PRP_SWEEP_TICKS;
    if (profileMode) begin
      prdFloor = avgOn ? PRP_AVG_TICKS : PRP_PROF_TICKS;
    end
    prdOk = firstFf || ((accFf >= target) && (prdCntFf >= prdFloor));
    res = profileMode ? spaceFf : CNT_W'(RES_MIN_TICKS);
    if (extTrig) begin
      minDly = DLY_W'(res) * DLY_W'(LAG_EXT_RES);
    end else begin
      minDly = -(DLY_W'(res) * DLY_W'(LEAD_INT_RES));
    end
    useDly = clampDly(curDlyFf, minDly);
    preTicks = (useDly < 0) ? CNT_W'(-useDly) : '0;
    if (extTrig) begin
      // one tick less: the realigned grid adds a tick after the edge
      sampTicks = CNT_W'(useDly - DLY_W'(1));
    end else begin
      sampTicks = (useDly < 0) ? '0 : CNT_W'(useDly);
    end
    widthTicks = (pulseWidth == '0) ? '0 : pulseWidth - 1'h1;
  end

  // ==========================================================
  // control
  always_comb begin
    nxt_state = stateFf;
    nxt_rem = remFf;
    nxt_quo = quoFf;
    nxt_step = stepFf;
    nxt_coarse = coarseFf;
    nxt_space = spaceFf;
    nxt_curDly = curDlyFf;
    nxt_idx = idxFf;
    nxt_first = firstFf;
    nxt_pendPulse = pendPulseFf;
    nxt_pendSamp = pendSampFf;
    nxt_pulseOn = pulseOnFf;
    nxt_prdCnt = prdCntFf;
    nxt_acc = accFf;
    nxt_sampTrig = 1'h0;
    nxt_tuneReq = 1'h0;
    nxt_halt = haltFf;
    nxt_busy = busyFf;
    nxt_done = 1'h0;
    leadIf.load = 1'h0;
    leadIf.val = preTicks;
    widthIf.load = 1'h0;
    widthIf.val = widthTicks;
    sampIf.load = 1'h0;
    sampIf.val = sampTicks;
    if (tickFf) begin
      if (prdCntFf != '1) begin
        nxt_prdCnt = prdCntFf + 1'h1;
      end
      if (accFf < target) begin
        nxt_acc = accFf + ACC_W'(duty);
      end
    end
    case (stateFf)
      ST_IDLE: begin
        nxt_halt = 1'h1;
        if (startInt || startTtl || startGet) begin
          nxt_busy = 1'h1;
          nxt_idx = '0;
          nxt_first = 1'h1;
          nxt_halt = 1'h0;
          nxt_coarse = 1'h0;
          if (profileMode) begin
            nxt_curDly = profStart;
            nxt_rem = '0;
            nxt_quo = QUO_W'(span) + QUO_W'(pts) - 1'h1;
            nxt_step = '0;
            nxt_state = ST_DIV;
          end else begin
            nxt_curDly = sweepDelay;
            nxt_space = CNT_W'(RES_MIN_TICKS);
            nxt_tuneReq = 1'h1;
            nxt_state = ST_SETUP;
          end
        end
      end
      ST_DIV: begin
        if (stepFf == STEP_W'(QUO_W)) begin
          if (!coarseFf && (quoFf > QUO_W'(COARSE_TICKS))) begin
            nxt_coarse = 1'h1;
            nxt_rem = '0;
            nxt_quo = QUO_W'(span) +
                      QUO_W'(int'(pts) * COARSE_TICKS) - 1'h1;
            nxt_step = '0;
          end else begin
            if (coarseFf) begin
              nxt_space = CNT_W'(quoFf * QUO_W'(COARSE_TICKS));
            end else if (quoFf < QUO_W'(RES_MIN_TICKS)) begin
              nxt_space = CNT_W'(RES_MIN_TICKS);
            end else begin
              nxt_space = CNT_W'(quoFf);
            end
            nxt_coarse = 1'h0;
            nxt_tuneReq = 1'h1;
            nxt_state = ST_SETUP;
          end
        end else begin
          nxt_step = stepFf + 1'h1;
          if (trial >= divisor) begin
            nxt_rem = trial - divisor;
            nxt_quo = {quoFf[QUO_W-2:0], 1'h1};
          end else begin
            nxt_rem = trial;
            nxt_quo = {quoFf[QUO_W-2:0], 1'h0};
          end
        end
      end
      ST_SETUP: begin
        if (setupDone) begin
          nxt_halt = 1'h1;
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (extTrig) begin
          if (zeroExt) begin
            sampIf.load = 1'h1;
            nxt_pendSamp = 1'h1;
            nxt_halt = 1'h0;
            nxt_state = ST_RUN;
          end
        end else if (prdOk && tickFf) begin
          // one pulse on the tick grid
          leadIf.load = 1'h1;
          sampIf.load = 1'h1;
          nxt_pendPulse = 1'h1;
          nxt_pendSamp = 1'h1;
          nxt_halt = 1'h0;
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // internal time zero and period start
        if (leadIf.done) begin
          nxt_pulseOn = 1'h1;
          widthIf.load = 1'h1;
          nxt_prdCnt = '0;
          nxt_acc = '0;
          nxt_first = 1'h0;
        end
        if (widthIf.done) begin
          nxt_pulseOn = 1'h0;
          nxt_pendPulse = 1'h0;
        end
        if (sampIf.done) begin
          nxt_sampTrig = 1'h1;
          nxt_pendSamp = 1'h0;
        end
        if (!pendPulseFf && !pendSampFf) begin
          nxt_idx = idxFf + 1'h1;
          if (idxFf + 1'h1 == pts) begin
            nxt_done = 1'h1;
            nxt_busy = 1'h0;
            nxt_halt = 1'h1;
            nxt_state = ST_IDLE;
          end else begin
            if (profileMode) begin
              nxt_curDly = curDlyFf + DLY_W'(spaceFf);
            end
            nxt_tuneReq = !profileMode;
            nxt_state = ST_SETUP;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_modOut = nxt_pulseOn ? pulseActiveHigh : !pulseActiveHigh;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stateFf <= ST_IDLE;
      remFf <= '0;
      quoFf <= '0;
      stepFf <= '0;
      coarseFf <= 1'h0;
      spaceFf <= CNT_W'(RES_MIN_TICKS);
      curDlyFf <= '0;
      idxFf <= '0;
      firstFf <= 1'h1;
      pendPulseFf <= 1'h0;
      pendSampFf <= 1'h0;
      pulseOnFf <= 1'h0;
      prdCntFf <= '0;
      accFf <= '0;
      modOutFf <= 1'h0;
      sampTrigFf <= 1'h0;
      tuneReqFf <= 1'h0;
      haltFf <= 1'h1;
      busyFf <= 1'h0;
      doneFf <= 1'h0;
    end else begin
      stateFf <= nxt_state;
      remFf <= nxt_rem;
      quoFf <= nxt_quo;
      stepFf <= nxt_step;
      coarseFf <= nxt_coarse;
      spaceFf <= nxt_space;
      curDlyFf <= nxt_curDly;
      idxFf <= nxt_idx;
      firstFf <= nxt_first;
      pendPulseFf <= nxt_pendPulse;
      pendSampFf <= nxt_pendSamp;
      pulseOnFf <= nxt_pulseOn;
      prdCntFf <= nxt_prdCnt;
      accFf <= nxt_acc;
      modOutFf <= nxt_modOut;
      sampTrigFf <= nxt_sampTrig;
      tuneReqFf <= nxt_tuneReq;
      haltFf <= nxt_halt;
      busyFf <= nxt_busy;
      doneFf <= nxt_done;
    end
  end

  // ==========================================================
  // outputs
  // halt gate out
  assign haltReady = haltFf;
  assign modOut = modOutFf;
  assign sampleTrig = sampTrigFf;
  assign tuneReq = tuneReqFf;
  assign busy = busyFf;
  assign measDone = doneFf;
  assign pointIdx = idxFf;
  assign resPeriod = spaceFf;
endmodule : pst_timing

/* File: test/pst_timing_props.sv */
// Purpose: port-level timing properties of pst_timing
// Assumes: one clock, srst synchronous active high
// Notes: bound into every pst_timing instance
`timescale 1ns/10ps
module pst_timing_props (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // controls
  input wire logic startInt,
  input wire logic startTtl,
  input wire logic startGet,
  input wire logic extTrig,
  input wire logic profileMode,
  input wire logic pulseActiveHigh,
  input wire pst_pkg::pst_pts_type numPoints,
  // results
  input wire logic modOut,
  input wire logic sampleTrig,
  input wire logic tuneReq,
  input wire logic haltReady,
  input wire logic busy,
  input wire logic measDone,
  input wire pst_pkg::pst_pts_type pointIdx,
  input wire pst_pkg::pst_cnt_type resPeriod
);
  import pst_pkg::*;
  logic pulseOn;
  assign pulseOn = modOut == pulseActiveHigh;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ======
  // properties
  AST_TUNE_ON_START: assert property (
    !busy && !profileMode && (startInt || startTtl || startGet)
    |=> busy && tuneReq && !haltReady) else $error("start gave no tuning");
  AST_SAMPLE_PULSE: assert property (
    sampleTrig |=> !sampleTrig) else $error("sample longer than a cycle");
  AST_SAMPLE_BUSY: assert property (
    sampleTrig |-> busy && !haltReady) else $error("sample while ready");
  AST_PULSE_BUSY: assert property (
    busy && pulseOn |-> !haltReady) else $error("ready during the pulse");
  AST_EXT_NO_PULSE: assert property (
    busy && extTrig |-> !pulseOn) else $error("pulse in external mode");
  AST_IDLE_LEVEL: assert property (
    (!busy && $stable(pulseActiveHigh)) [*2] |-> !pulseOn)
    else $error("modulator active while idle");
  AST_DONE_COUNT: assert property (
    measDone |-> !busy && haltReady &&
    pointIdx == ((numPoints == 0) ? 1 : numPoints))
    else $error("run ended with wrong point count");
  AST_DONE_ONCE: assert property (
    measDone |=> !measDone && !busy) else $error("end of run repeated");
  AST_SWEEP_RES: assert property (
    sampleTrig && !profileMode |-> resPeriod == 1)
    else $error("sweep spacing not one tick");
  AST_COARSE_RES: assert property (
    sampleTrig && profileMode && resPeriod > COARSE_TICKS
    |-> resPeriod % COARSE_TICKS == 0) else $error("coarse spacing off");
  cover property (sampleTrig && profileMode && extTrig);
  cover property (sampleTrig && !profileMode && !pulseOn);
  cover property (measDone && profileMode);
endmodule : pst_timing_props

bind pst_timing pst_timing_props i_props (
  .clk(clk), .srst(srst), .startInt(startInt), .startTtl(startTtl),
  .startGet(startGet), .extTrig(extTrig), .profileMode(profileMode),
  .pulseActiveHigh(pulseActiveHigh), .numPoints(numPoints),
  .modOut(modOut), .sampleTrig(sampleTrig), .tuneReq(tuneReq),
  .haltReady(haltReady), .busy(busy), .measDone(measDone),
  .pointIdx(pointIdx), .resPeriod(resPeriod));

/* File: test/pst_far_end.sv */
// Purpose: far side: tuning answer and external trigger source
// Assumes: driven on the falling clock edge, trigger idles high
// Notes: setup delay set per run, so setup comes promptly or slowly
`timescale 1ns/10ps
module pst_far_end #(
  parameter int TRIG_WAIT = 7
) (
  // clock and mode
  input wire logic clk,
  input wire logic extMode,
  input wire logic [7:0] setupDly,
  // from the timing block
  input wire logic tuneReq,
  input wire logic haltReady,
  input wire logic busy,
  // to the timing block
  output logic setupDone,
  output logic extTrigIn
);
  int waitCnt = 0;
  int readyCnt = 0;
  int lowCnt = 0;
  initial setupDone = 1'h0;
  initial extTrigIn = 1'h1;
  always @(negedge clk) begin
    if (tuneReq === 1'b1) begin
      setupDone <= 1'h0;
      waitCnt = setupDly;
    end else if (waitCnt > 0) begin
      waitCnt--;
    end else begin
      setupDone <= 1'h1;
    end
    // one falling edge per ready point
    readyCnt = (haltReady === 1'b1 && busy === 1'b1) ? readyCnt + 1 : 0;
    if (extMode && readyCnt == TRIG_WAIT) lowCnt = 5;
    else if (lowCnt > 0) lowCnt--;
    extTrigIn <= (lowCnt == 0);
  end
endmodule : pst_far_end

/* File: test/tb.sv */
// Purpose: self-checking bench for pst_timing
// Assumes: short period floors, far side from pst_far_end
// Notes: expected timing rebuilt from cycle stamps at each end of run
`timescale 1ns/10ps
module tb;
  import pst_pkg::*;
  localparam int FL_SW = 50;
  localparam int FL_PR = 20;
  localparam int FL_AV = 10;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic startInt = 1'h0;
  logic startTtl = 1'h0;
  logic startGet = 1'h0;
  logic extTrig = 1'h0;
  logic profileMode = 1'h0;
  logic avgOn = 1'h0;
  logic pulseActiveHigh = 1'h1;
  pst_cnt_type pulseWidth = 19'h1;
  pst_pct_type dutyLimit = 7'h64;
  pst_dly_type sweepDelay = 24'h0;
  pst_dly_type profStart = 24'h0;
  pst_cnt_type profStop = 19'h0;
  pst_pts_type numPoints = 10'h1;
  logic [7:0] setupDly = 8'h0;
  logic setupDone, extTrigIn, modOut, sampleTrig, tuneReq, haltReady;
  logic busy, measDone;
  pst_pts_type pointIdx;
  pst_cnt_type resPeriod;
  logic [31:0] rp;
  int cyc = 0;
  int mismatches = 0;
  int n_checks = 0;
  int tunes = 0;
  int seed = 39;
  int on[$], off[$], samp[$], fall[$];
  bit actPrev, extPrev, done;
  always #5 clk = ~clk;
  pst_timing #(.PRP_SWEEP_TICKS(19'h32), .PRP_PROF_TICKS(19'h14),
    .PRP_AVG_TICKS(19'hA)) i_dut (
    .clk(clk), .srst(srst), .startInt(startInt), .startTtl(startTtl),
    .startGet(startGet), .extTrig(extTrig), .profileMode(profileMode),
    .avgOn(avgOn), .pulseActiveHigh(pulseActiveHigh),
    .pulseWidth(pulseWidth), .dutyLimit(dutyLimit),
    .sweepDelay(sweepDelay), .profStart(profStart), .profStop(profStop),
    .numPoints(numPoints), .setupDone(setupDone), .extTrigIn(extTrigIn),
    .modOut(modOut), .sampleTrig(sampleTrig), .tuneReq(tuneReq),
    .haltReady(haltReady), .busy(busy), .measDone(measDone),
    .pointIdx(pointIdx), .resPeriod(resPeriod));
  pst_far_end i_far (.clk(clk), .extMode(extTrig), .setupDly(setupDly),
    .tuneReq(tuneReq), .haltReady(haltReady), .busy(busy),
    .setupDone(setupDone), .extTrigIn(extTrigIn));
  // ======
  // checking
  task automatic stop_test();
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, int e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  // events may sit two cycles off the tick edge
  task automatic near(string nm, int e, int g);
    chk(nm, e, (g >= e - 2 && g <= e + 2) ? e : g);
  endtask : near
  function automatic int rnd(int m);
    return $unsigned($random(seed)) % m;
  endfunction : rnd
  task automatic check_run();
    int n, w, mx, sp, d, mn, lim, bs;
    n = (numPoints == 0) ? 1 : numPoints;
    w = (pulseWidth == 0) ? 1 : pulseWidth;
    mx = (w > profStop) ? w : profStop;
    sp = profileMode ? (mx + n - 1) / n : 1;
    if (sp > 100) sp = (mx + n * 100 - 1) / (n * 100) * 100;
    lim = (dutyLimit == 0) ? 1 : (dutyLimit > 100) ? 100 : dutyLimit;
    lim = w * 100 / lim;
    mn = !profileMode ? FL_SW : avgOn ? FL_AV : FL_PR;
    if (lim < mn) lim = mn;
    chk("samples", n, samp.size());
    chk("pulses", extTrig ? 0 : n, on.size());
    chk("trigger edges", extTrig ? n : 0, fall.size());
    chk("pointIdx", n, pointIdx);
    chk("tune requests", profileMode ? 1 : n, tunes);
    chk("resPeriod", sp, rp);
    for (int k = 0; k < samp.size() &&
         k < (extTrig ? fall.size() : on.size()); k++) begin
      d = profileMode ? profStart + k * sp : sweepDelay;
      mn = extTrig ? 3 * sp : -6 * sp;
      if (d < mn) d = mn;
      if (d > 408800) d = 408800;
      bs = extTrig ? fall[k] : on[k];
      near("delay", d * 10, samp[k] - bs);
      if (!extTrig) near("width", w * 10, off[k] - on[k]);
      if (!extTrig && k > 0)
        chk("period", 1, on[k] - on[k-1] >= lim * 10 - 2);
    end
  endtask : check_run
  always @(posedge clk) begin
    cyc++;
    if (cyc > 80000) begin
      mismatches++;
      stop_test();
    end
  end
  // outputs settle after the rising edge, so stamp them at the falling one
  always @(negedge clk) begin
    if (!srst) begin
      if ((modOut === pulseActiveHigh) != actPrev) begin
        if (actPrev) off.push_back(cyc);
        else on.push_back(cyc);
        actPrev = !actPrev;
      end
      if (sampleTrig === 1'b1) begin
        samp.push_back(cyc);
        rp = resPeriod;
      end
      if (extPrev && extTrigIn === 1'b0) fall.push_back(cyc);
      extPrev = (extTrigIn === 1'b1);
      if (tuneReq === 1'b1) tunes++;
      if (measDone === 1'b1) begin
        check_run();
        done = 1;
      end
    end
  end
  // ======
  // stimulus
  task automatic run(int ext, prof, w, d, pts, duty, stp, avg, src, pah,
    sd);
    @(negedge clk);
    extTrig = ext[0];
    profileMode = prof[0];
    pulseWidth = CNT_W'(w);
    sweepDelay = DLY_W'(d);
    profStart = DLY_W'(d);
    numPoints = PTS_W'(pts);
    dutyLimit = PCT_W'(duty);
    profStop = CNT_W'(stp);
    avgOn = avg[0];
    pulseActiveHigh = pah[0];
    setupDly = 8'(sd);
    repeat (2) @(negedge clk);
    on.delete();
    off.delete();
    samp.delete();
    fall.delete();
    tunes = 0;
    done = 0;
    {startGet, startTtl, startInt} = 3'h1 << src;
    @(negedge clk);
    {startGet, startTtl, startInt} = 3'h0;
    repeat (3) @(negedge clk);
    // start inside a run is ignored
    {startGet, startTtl, startInt} = 3'h7;
    @(negedge clk);
    {startGet, startTtl, startInt} = 3'h0;
    while (!done) @(negedge clk);
  endtask : run
  initial begin
    repeat (20) @(negedge clk);
    chk("busy", 0, busy);
    chk("haltReady", 1, haltReady);
    chk("resPeriod", 1, resPeriod);
    srst = 1'h0;
    run(0, 0, 5, 2, 3, 50, 0, 0, 0, 1, 0);
    run(0, 0, 0, -6, 2, 100, 0, 0, 1, 0, 40);
    run(0, 0, 20, 25, 2, 10, 0, 0, 2, 1, 3);
    run(1, 0, 4, 1, 3, 50, 0, 0, 0, 1, 5);
    run(0, 1, 8, -14, 4, 100, 4, 0, 1, 1, 0);
    run(0, 1, 500, 0, 3, 100, 0, 1, 2, 0, 2);
    run(1, 1, 2, 25, 3, 50, 30, 0, 0, 1, 0);
    for (int i = 0; i < 2; i++)
      run(0, 0, 1 + rnd(30), rnd(40), 2, 20 + rnd(81), 0, 0, rnd(3), 1,
        rnd(20));
    stop_test();
  end
endmodule : tb
